// >>> hw/edge_sync.sv
// Two-flop synchroniser with falling and rising edge pulses, W lanes.
// Assumes inputs that hold each level for at least two clock cycles.
`timescale 1ns/1ns
`default_nettype none
module edge_sync #(
    parameter int W = 6
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Raw inputs
    input wire logic [W-1:0] din,
    // Synchronised edges
    output logic [W-1:0] fall,
    output logic [W-1:0] rise
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] prev;
    } sync_s;

    sync_s st_q;
    sync_s st_d;

    always_comb begin
        st_d = st_q;
        st_d.s1 = din;
        st_d.s2 = st_q.s1;
        st_d.prev = st_q.s2;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // Only s2 and prev are compared; s1 may be metastable
    assign fall = st_q.prev & ~st_q.s2;
    assign rise = ~st_q.prev & st_q.s2;
endmodule : edge_sync
`default_nettype wire

// >>> hw/qct_pkg.sv
// Constants for the quad counter/timer unit: register map, field layout, codes.
// Assumes a 32-bit Avalon-MM slave with byte addresses and a single clock.
package qct_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_MODE = 8'h00;
    localparam logic [7:0] OFS_CLK = 8'h04;
    localparam logic [7:0] OFS_RUN = 8'h08;
    localparam logic [7:0] OFS_CNT0 = 8'h0c;
    localparam logic [7:0] OFS_CNT1 = 8'h10;
    localparam logic [7:0] OFS_AR_BASE = 8'h14;
    localparam logic [7:0] OFS_AR_END = 8'h34;
    localparam logic [7:0] OFS_STS = 8'h34;
    localparam logic [7:0] OFS_MASK = 8'h38;
    // Register offsets inside one auto-reload timer block
    localparam logic [3:0] AR_CTRL = 4'h0;
    localparam logic [3:0] AR_REL = 4'h4;
    localparam logic [3:0] AR_CNT = 4'h8;
    localparam logic [3:0] AR_CAP = 4'hc;
    localparam int AR_SEL_BIT = 4;
    // Classic mode register: one 4-bit field per timer
    localparam int CL_FIELD_W = 4;
    localparam int CL_MODE_LSB = 0;
    localparam int CL_CT_BIT = 2;
    localparam int CL_GATE_BIT = 3;
    localparam int MODE_W = 8;
    // Clock control register
    localparam int PRESC_LSB = 0;
    localparam int CSEL_LSB = 2;
    localparam int GPOL_LSB = 4;
    localparam int CLK_W = 6;
    // Classic timer modes
    localparam logic [1:0] CM_13 = 2'h0;
    localparam logic [1:0] CM_16 = 2'h1;
    localparam logic [1:0] CM_8AR = 2'h2;
    localparam logic [1:0] CM_SPLIT = 2'h3;
    localparam int C13_LO_W = 5;
    // Shared prescale codes and divisors
    localparam logic [1:0] PS_DIV12 = 2'h0;
    localparam logic [1:0] PS_DIV4 = 2'h1;
    localparam logic [1:0] PS_DIV48 = 2'h2;
    localparam logic [1:0] PS_EXT8 = 2'h3;
    localparam int DIV12 = 12;
    localparam int DIV4 = 4;
    localparam int DIV48 = 48;
    localparam int DIV8 = 8;
    // Auto-reload control bits and clock sources
    localparam int AR_RUN = 0;
    localparam int AR_SPLIT = 1;
    localparam int AR_CAPT = 2;
    localparam int AR_CAPSEL = 3;
    localparam int AR_SRC_LSB = 4;
    localparam int AR_CTRL_W = 6;
    localparam logic [1:0] SRC_SYS = 2'h0;
    localparam logic [1:0] SRC_DIV12 = 2'h1;
    localparam logic [1:0] SRC_OSC8 = 2'h2;
    localparam logic [1:0] SRC_CMP = 2'h3;
    // Interrupt status bits
    localparam int ST_TF0 = 0;
    localparam int ST_TF1 = 1;
    localparam int ST_AR_LO = 2;
    localparam int ST_AR_HI = 3;
    localparam int ST_CAP = 6;
    localparam int STS_W = 8;
    // Synchroniser lanes
    localparam int SY_EVA = 0;
    localparam int SY_EVB = 1;
    localparam int SY_RTC = 2;
    localparam int SY_OSC = 3;
    localparam int SY_CMPA = 4;
    localparam int SY_CMPB = 5;
    localparam int SY_W = 6;
endpackage : qct_pkg

// >>> hw/quad_counter_timer_unit.sv
// Quad counter/timer unit: two classic counter/timers, two auto-reload timers,
// an Avalon-MM register slave with waitrequest and a masked interrupt.
// Assumes all inputs synchronous to clk except the event, oscillator and comparator pins.
//
// What this block does
// - Two 16-bit classic counter/timers with the legacy timer behaviour.
// - Two 16-bit auto-reload timers for general timing use.
// - Classic modes: 13-bit, 16-bit, 8-bit auto-reload, and split only on timer 0.
// - Each auto-reload timer runs as one 16-bit or two 8-bit reloading halves.
// - Auto-reload timers capture their count on RTC or comparator edges.
// - Classic clocks come from five sources via clock-select and prescale bits.
// - A classic timer counts the prescaled clock or the system clock.
// - Auto-reload timers may count the system clock or it divided by 12.
// - Auto-reload timer 0 may also count RTC/8 or comparator A.
// - Auto-reload timer 1 may also count external oscillator/8 or comparator B.
// - In counter mode a classic timer counts falling edges of its event pin.
// - Event inputs are counted correctly up to a quarter of the clock rate.
// - Prescale picks sysclk/12, /4, /48 or synchronised external clock/8.
// - Outside split mode, classic timers count while run and (not gated or gate input active).
// - A classic overflow, except timer 1's while timer 0 splits, sets its flag, which raises the interrupt if enabled.
//
// The implementer's own choices: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ns
`default_nettype none
module quad_counter_timer_unit #(
    parameter int CW = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Avalon-MM slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Event and clock pins
    input wire logic event_input_a,
    input wire logic event_input_b,
    input wire logic external_gate_input_a,
    input wire logic external_gate_input_b,
    input wire logic rtc_osc_in,
    input wire logic ext_osc_in,
    input wire logic comparator_a,
    input wire logic comparator_b,
    // Interrupt
    output logic irq
);
    typedef struct packed {
        logic [qct_pkg::MODE_W-1:0] cl_mode;
        logic [qct_pkg::CLK_W-1:0] clk_ctrl;
        logic [1:0] classic_run_bit;
        logic [1:0][CW-1:0] cl_cnt;
        logic [1:0][qct_pkg::AR_CTRL_W-1:0] ar_ctrl;
        logic [1:0][CW-1:0] ar_rel;
        logic [1:0][CW-1:0] ar_cnt;
        logic [1:0][CW-1:0] ar_cap;
        logic [1:0][2:0] div8;
        logic [3:0] p12;
        logic [5:0] p48;
        logic [qct_pkg::STS_W-1:0] sts;
        logic [qct_pkg::STS_W-1:0] mask;
        logic wreq;
        logic [31:0] rdata;
        logic irq;
    } state_s;

    state_s st_q;
    state_s st_d;

    logic [qct_pkg::SY_W-1:0] fall;
    logic [qct_pkg::SY_W-1:0] rise;

    // Byte-enable merge of a write into a register
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
        logic [31:0] m;
        for (int b = 0; b < 4; b++) begin
            m[b*8 +: 8] = {8{be[b]}};
        end
        return (old & ~m) | (wd & m);
    endfunction : merge

    // One classic count step: bit 16 is the overflow, low 16 the new count
    function automatic logic [16:0] classic_step(input logic [1:0] mode,
                                                 input logic [15:0] c);
        logic [13:0] s14;
        logic [16:0] s17;
        logic [8:0] s9;
        s14 = {1'b0, c[15:8], c[qct_pkg::C13_LO_W-1:0]} + 14'h1;
        s17 = {1'b0, c} + 17'h1;
        s9 = {1'b0, c[7:0]} + 9'h1;
        case (mode)
            qct_pkg::CM_13: begin
                return {s14[13], s14[12:5], c[7:5], s14[4:0]};
            end
            qct_pkg::CM_16: begin
                return s17;
            end
            qct_pkg::CM_8AR: begin
                return s9[8] ? {1'b1, c[15:8], c[15:8]} : {1'b0, c[15:8], s9[7:0]};
            end
            default: begin
                return {s9[8], c[15:8], s9[7:0]};
            end
        endcase
    endfunction : classic_step

    // 8-bit reloading step: bit 8 is the overflow
    function automatic logic [8:0] step8(input logic [7:0] c, input logic [7:0] r);
        logic [8:0] s;
        s = {1'b0, c} + 9'h1;
        return s[8] ? {1'b1, r} : s;
    endfunction : step8

    edge_sync #(
        .W(qct_pkg::SY_W)
    ) u_sync (
        .clk(clk),
        .rst(rst),
        .din({comparator_b, comparator_a, ext_osc_in, rtc_osc_in,
              event_input_b, event_input_a}),
        .fall(fall),
        .rise(rise)
    );

    // Combinational terms
    logic bus_go;
    logic bus_wr;
    logic [31:0] rd;
    logic [7:0] arofs;
    logic ai;
    logic tick12;
    logic tick4;
    logic tick48;
    logic [1:0] osc8;
    logic presc_tick;
    logic [1:0] cl_tick;
    logic [1:0] cl_en;
    logic [1:0] gate_in;
    logic [1:0] cl_split;
    logic [16:0] st0;
    logic [16:0] st1;
    logic [8:0] hi0;
    logic [1:0] ar_tick;
    logic [1:0] cap_ev;
    logic [16:0] a16;
    logic [8:0] alo;
    logic [8:0] ahi;
    logic [qct_pkg::STS_W-1:0] set;
    logic [qct_pkg::STS_W-1:0] clr;
    logic [31:0] wd;

    assign gate_in = {external_gate_input_b, external_gate_input_a};

    always_comb begin
        st_d = st_q;
        set = '0;
        clr = '0;
        rd = '0;
        wd = '0;
        st0 = '0;
        st1 = '0;
        hi0 = '0;
        a16 = '0;
        alo = '0;
        ahi = '0;
        cl_split = '0;
        // Taken with waitrequest high, done one cycle later
        bus_go = (avs_read | avs_write) & st_q.wreq;
        bus_wr = avs_write & ~st_q.wreq;
        arofs = avs_address - qct_pkg::OFS_AR_BASE;
        ai = arofs[qct_pkg::AR_SEL_BIT];

        // Prescaler chain, free running
        tick12 = st_q.p12 == 4'(qct_pkg::DIV12 - 1);
        tick4 = st_q.p48[1:0] == 2'(qct_pkg::DIV4 - 1);
        tick48 = st_q.p48 == 6'(qct_pkg::DIV48 - 1);
        st_d.p12 = tick12 ? 4'h0 : st_q.p12 + 4'h1;
        st_d.p48 = tick48 ? 6'h0 : st_q.p48 + 6'h1;
        // Divide-by-8 of RTC (lane 0) and external oscillator (lane 1)
        for (int i = 0; i < 2; i++) begin
            osc8[i] = rise[qct_pkg::SY_RTC + i] & (st_q.div8[i] == 3'(qct_pkg::DIV8 - 1));
            if (rise[qct_pkg::SY_RTC + i]) begin
                st_d.div8[i] = st_q.div8[i] + 3'h1;
            end
        end
        case (st_q.clk_ctrl[qct_pkg::PRESC_LSB +: 2])
            qct_pkg::PS_DIV12: presc_tick = tick12;
            qct_pkg::PS_DIV4: presc_tick = tick4;
            qct_pkg::PS_DIV48: presc_tick = tick48;
            qct_pkg::PS_EXT8: presc_tick = osc8[1];
            default: presc_tick = 1'b0;
        endcase

        // Classic timers: tick source and enable
        for (int i = 0; i < 2; i++) begin
            if (st_q.cl_mode[i*qct_pkg::CL_FIELD_W + qct_pkg::CL_CT_BIT]) begin
                cl_tick[i] = fall[qct_pkg::SY_EVA + i];
            end else begin
                // Five sources: sysclk or one of four prescaled clocks
                cl_tick[i] = st_q.clk_ctrl[qct_pkg::CSEL_LSB + i] | presc_tick;
            end
            cl_en[i] = st_q.classic_run_bit[i] &
                (~st_q.cl_mode[i*qct_pkg::CL_FIELD_W + qct_pkg::CL_GATE_BIT] |
                 (gate_in[i] == st_q.clk_ctrl[qct_pkg::GPOL_LSB + i]));
        end
        cl_split[0] = st_q.cl_mode[qct_pkg::CL_MODE_LSB +: 2] == qct_pkg::CM_SPLIT;
        cl_split[1] = st_q.cl_mode[qct_pkg::CL_FIELD_W + qct_pkg::CL_MODE_LSB +: 2]
            == qct_pkg::CM_SPLIT;

        // Timer 0; when split, its high byte runs on timer 1's run bit
        st0 = classic_step(st_q.cl_mode[qct_pkg::CL_MODE_LSB +: 2], st_q.cl_cnt[0]);
        if (cl_en[0] & cl_tick[0]) begin
            st_d.cl_cnt[0][7:0] = st0[7:0];
            set[qct_pkg::ST_TF0] = st0[16];
            if (!cl_split[0]) begin
                st_d.cl_cnt[0][15:8] = st0[15:8];
            end
        end
        hi0 = {1'b0, st_q.cl_cnt[0][15:8]} + 9'h1;
        if (cl_split[0] & st_q.classic_run_bit[1] &
            (st_q.clk_ctrl[qct_pkg::CSEL_LSB] | presc_tick)) begin
            st_d.cl_cnt[0][15:8] = hi0[7:0];
            set[qct_pkg::ST_TF1] = hi0[8];
        end
        // Timer 1 holds in split; while timer 0 splits it sets no flag
        st1 = classic_step(st_q.cl_mode[qct_pkg::CL_FIELD_W +: 2], st_q.cl_cnt[1]);
        if (cl_en[1] & cl_tick[1] & ~cl_split[1]) begin
            st_d.cl_cnt[1] = st1[15:0];
            set[qct_pkg::ST_TF1] = set[qct_pkg::ST_TF1] | (st1[16] & ~cl_split[0]);
        end

        // Auto-reload timers
        for (int i = 0; i < 2; i++) begin
            case (st_q.ar_ctrl[i][qct_pkg::AR_SRC_LSB +: 2])
                qct_pkg::SRC_SYS: ar_tick[i] = 1'b1;
                qct_pkg::SRC_DIV12: ar_tick[i] = tick12;
                qct_pkg::SRC_OSC8: ar_tick[i] = osc8[i];
                qct_pkg::SRC_CMP: ar_tick[i] = rise[qct_pkg::SY_CMPA + i];
                default: ar_tick[i] = 1'b0;
            endcase
            cap_ev[i] = st_q.ar_ctrl[i][qct_pkg::AR_CAPSEL] ?
                rise[qct_pkg::SY_CMPA + i] : rise[qct_pkg::SY_RTC];
            a16 = {1'b0, st_q.ar_cnt[i]} + 17'h1;
            alo = step8(st_q.ar_cnt[i][7:0], st_q.ar_rel[i][7:0]);
            ahi = step8(st_q.ar_cnt[i][15:8], st_q.ar_rel[i][15:8]);
            if (st_q.ar_ctrl[i][qct_pkg::AR_RUN] & ar_tick[i]) begin
                if (st_q.ar_ctrl[i][qct_pkg::AR_SPLIT]) begin
                    st_d.ar_cnt[i] = {ahi[7:0], alo[7:0]};
                    set[qct_pkg::ST_AR_LO + 2*i] = alo[8];
                    set[qct_pkg::ST_AR_HI + 2*i] = ahi[8];
                end else begin
                    st_d.ar_cnt[i] = a16[16] ? st_q.ar_rel[i] : a16[15:0];
                    set[qct_pkg::ST_AR_HI + 2*i] = a16[16];
                end
            end
            // Capture takes the count before this cycle's increment
            if (st_q.ar_ctrl[i][qct_pkg::AR_CAPT] & cap_ev[i]) begin
                st_d.ar_cap[i] = st_q.ar_cnt[i];
                set[qct_pkg::ST_CAP + i] = 1'b1;
            end
        end

        // Register read decode
        case (avs_address)
            qct_pkg::OFS_MODE: rd = 32'(st_q.cl_mode);
            qct_pkg::OFS_CLK: rd = 32'(st_q.clk_ctrl);
            qct_pkg::OFS_RUN: rd = 32'(st_q.classic_run_bit);
            qct_pkg::OFS_CNT0: rd = 32'(st_q.cl_cnt[0]);
            qct_pkg::OFS_CNT1: rd = 32'(st_q.cl_cnt[1]);
            qct_pkg::OFS_STS: rd = 32'(st_q.sts);
            qct_pkg::OFS_MASK: rd = 32'(st_q.mask);
            default: begin
                if (avs_address >= qct_pkg::OFS_AR_BASE && avs_address < qct_pkg::OFS_AR_END) begin
                    case (arofs[3:0])
                        qct_pkg::AR_CTRL: rd = 32'(st_q.ar_ctrl[ai]);
                        qct_pkg::AR_REL: rd = 32'(st_q.ar_rel[ai]);
                        qct_pkg::AR_CNT: rd = 32'(st_q.ar_cnt[ai]);
                        qct_pkg::AR_CAP: rd = 32'(st_q.ar_cap[ai]);
                        default: rd = '0;
                    endcase
                end
            end
        endcase

        // A write beats a count step in the same cycle
        if (bus_wr) begin
            wd = merge(rd, avs_writedata, avs_byteenable);
            case (avs_address)
                qct_pkg::OFS_MODE: st_d.cl_mode = wd[qct_pkg::MODE_W-1:0];
                qct_pkg::OFS_CLK: st_d.clk_ctrl = wd[qct_pkg::CLK_W-1:0];
                qct_pkg::OFS_RUN: st_d.classic_run_bit = wd[1:0];
                qct_pkg::OFS_CNT0: st_d.cl_cnt[0] = wd[CW-1:0];
                qct_pkg::OFS_CNT1: st_d.cl_cnt[1] = wd[CW-1:0];
                qct_pkg::OFS_STS: begin
                    for (int b = 0; b < 1; b++) begin
                        clr = avs_byteenable[b] ? avs_writedata[qct_pkg::STS_W-1:0] : '0;
                    end
                end
                qct_pkg::OFS_MASK: st_d.mask = wd[qct_pkg::STS_W-1:0];
                default: begin
                    if (avs_address >= qct_pkg::OFS_AR_BASE &&
                        avs_address < qct_pkg::OFS_AR_END) begin
                        case (arofs[3:0])
                            qct_pkg::AR_CTRL: st_d.ar_ctrl[ai] = wd[qct_pkg::AR_CTRL_W-1:0];
                            qct_pkg::AR_REL: st_d.ar_rel[ai] = wd[CW-1:0];
                            qct_pkg::AR_CNT: st_d.ar_cnt[ai] = wd[CW-1:0];
                            default: st_d.ar_cnt[ai] = st_d.ar_cnt[ai];
                        endcase
                    end
                end
            endcase
        end

        // A hardware set beats a same-cycle clear
        st_d.sts = (st_q.sts & ~clr) | set;
        st_d.irq = |(st_d.sts & st_d.mask);

        // Bus handshake
        if (bus_go) begin
            st_d.wreq = 1'b0;
            st_d.rdata = rd;
        end else if (!st_q.wreq) begin
            st_d.wreq = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_q <= '0;
            st_q.wreq <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    assign avs_readdata = st_q.rdata;
    assign avs_waitrequest = st_q.wreq;
    assign irq = st_q.irq;
endmodule : quad_counter_timer_unit
`default_nettype wire

// >>> sim/pin_model.sv
// Far-side pin sources for the counter/timer unit.
// Assumes the unit's clock.
`timescale 1ns/1ns
`default_nettype none
module pin_model (
    // Clock
    input wire logic clk,
    // Event pins
    output logic ev_a,
    output logic ev_b,
    // Slow clocks and comparators
    output logic rtc,
    output logic osc,
    output logic cmp_a,
    output logic cmp_b
);
    int ph = 0;
    initial begin
        ev_a = 1'b1;
        ev_b = 1'b1;
        rtc = 1'b0;
        osc = 1'b0;
        cmp_a = 1'b0;
        cmp_b = 1'b0;
    end
    // Free running: phase drifts against the dividers
    always @(posedge clk) begin
        ph <= ph + 1;
        rtc <= ph[2];
        osc <= ph[3];
        cmp_a <= (ph % 10) >= 5;
        cmp_b <= (ph % 20) >= 10;
    end
    // Two cycles a level: the fastest legal rate
    task automatic burst(input logic b, input int n);
        repeat (n) begin
            @(posedge clk);
            if (b) ev_b <= 1'b0;
            else ev_a <= 1'b0;
            repeat (2) @(posedge clk);
            ev_a <= 1'b1;
            ev_b <= 1'b1;
            @(posedge clk);
        end
    endtask : burst
endmodule : pin_model
`default_nettype wire

// >>> sim/qct_monitor.sv
// Port checker for the counter/timer unit.
// Assumes read and write never high together.
`timescale 1ns/1ns
`default_nettype none
module qct_monitor (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Avalon-MM slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // Interrupt
    input wire logic irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic req;
    assign req = avs_read | avs_write;
    a_wait_answer: assert property (req && avs_waitrequest |=> !avs_waitrequest)
        else $error("waitrequest stuck high");
    a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    a_wait_cause: assert property (!avs_waitrequest |-> $past(req) && $past(avs_waitrequest))
        else $error("answer without request");
    a_first_wait: assert property ($rose(req) |-> avs_waitrequest)
        else $error("no wait cycle");
    a_rdata_hold: assert property (!req |=> $stable(avs_readdata))
        else $error("readdata changed idle");
    a_cnt_upper: assert property (avs_read && !avs_waitrequest &&
        (avs_address == qct_pkg::OFS_CNT0 || avs_address == qct_pkg::OFS_CNT1)
        |-> avs_readdata[31:16] == 16'h0000)
        else $error("count upper bits set");
    a_mask_irq_off: assert property (avs_write && !avs_waitrequest &&
        avs_byteenable[0] && avs_address == qct_pkg::OFS_MASK && avs_writedata[7:0] == 8'h00
        |-> ##2 !irq)
        else $error("irq high while masked");
    a_irq_reset: assert property ($fell(rst) |-> !irq)
        else $error("irq high after reset");
endmodule : qct_monitor
`default_nettype wire

// >>> sim/tb.sv
// Self-checking bench for the quad counter/timer unit.
// Assumes a one-wait-cycle register slave.
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic gate_a = 1'b0;
    logic gate_b = 1'b0;
    logic ev_a, ev_b, rtc, osc, cmp_a, cmp_b, irq;
    logic [31:0] q;
    logic [31:0] q2;
    int err_total = 0;
    int n_tests = 0;
    int seed = 29;
    int dv [5] = '{12, 4, 48, 128, 1};
    int ard [2][4] = '{'{1, 12, 64, 10}, '{1, 12, 128, 20}};
    localparam logic [7:0] RMODE = qct_pkg::OFS_MODE, RCLK = qct_pkg::OFS_CLK,
        RRUN = qct_pkg::OFS_RUN, RCNT0 = qct_pkg::OFS_CNT0, RCNT1 = qct_pkg::OFS_CNT1,
        RSTS = qct_pkg::OFS_STS, RMASK = qct_pkg::OFS_MASK;
    logic [7:0] regs [7] = '{RMODE, RCLK, RRUN, RCNT0, RCNT1, RSTS, RMASK};
    always #2 clk = ~clk;
    quad_counter_timer_unit u_dut (.clk(clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .event_input_a(ev_a), .event_input_b(ev_b), .external_gate_input_a(gate_a),
        .external_gate_input_b(gate_b), .rtc_osc_in(rtc), .ext_osc_in(osc),
        .comparator_a(cmp_a), .comparator_b(cmp_b), .irq(irq));
    pin_model u_pins (.clk(clk), .ev_a(ev_a), .ev_b(ev_b), .rtc(rtc), .osc(osc),
        .cmp_a(cmp_a), .cmp_b(cmp_b));
    function automatic int rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic logic [7:0] ar(input int n, input logic [3:0] o);
        return qct_pkg::OFS_AR_BASE + 8'(n * 16) + {4'h0, o};
    endfunction : ar
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : report_and_stop
    // Holds the request until waitrequest is seen low at a rising edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do begin
            @(posedge clk);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 40);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (k >= 40) begin
            err_total++;
            report_and_stop();
        end
    endtask : xfer
    task automatic rd(input logic [7:0] a);
        xfer(1'b0, a, 32'h0);
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask : wr
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic chkr(input string nm, input int lo, input int hi, input logic [31:0] g);
        n_tests++;
        if ((^g === 1'bx) || g < lo || g > hi) begin
            err_total++;
            $display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, g);
        end
    endtask : chkr
    task automatic window(input logic [7:0] a, input logic [31:0] on, input int k);
        wr(a, on);
        repeat (k) @(posedge clk);
        wr(a, 32'h0);
    endtask : window
    initial begin
        int n;
        int s;
        int e;
        logic [7:0] ca;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        foreach (regs[i]) begin
            rd(regs[i]);
            chk("reset value", 32'h0, q);
        end
        wr(8'h3c, rnd());
        rd(8'h3c);
        chk("unmapped word", 32'h0, q);
        $display("test reset done");
        for (int t = 0; t < 2; t++) begin
            n = 1 + (rnd() & 15);
            s = 65536 - n;
            ca = t ? RCNT1 : RCNT0;
            wr(RMODE, t ? 32'h50 : 32'h05);
            wr(ca, s);
            wr(RMASK, 1 << t);
            wr(RRUN, 1 << t);
            u_pins.burst(t, n);
            repeat (4) @(posedge clk);
            rd(ca);
            chk("event count", (s + n) & 16'hffff, q);
            chk("irq raised", 32'h1, {31'h0, irq});
            rd(RSTS);
            chk("overflow flag", 1 << t, q);
            wr(RSTS, 1 << t);
            repeat (2) @(posedge clk);
            chk("irq cleared", 32'h0, {31'h0, irq});
            wr(RMASK, 32'h0);
        end
        wr(RMODE, 32'h04);
        wr(RCNT0, 32'hff1e);
        wr(RRUN, 32'h1);
        u_pins.burst(0, 3);
        repeat (4) @(posedge clk);
        rd(RCNT0);
        chk("13-bit wrap", 32'h0001, q & 32'hff1f);
        rd(RSTS);
        chk("13-bit flag", 32'h1, q);
        wr(RSTS, 32'hff);
        $display("test event counting done");
        wr(RMODE, 32'hd0);
        wr(RCLK, 32'h20);
        wr(RCNT1, 32'h0);
        wr(RRUN, 32'h2);
        u_pins.burst(1, 3);
        gate_b <= 1'b1;
        u_pins.burst(1, 3);
        repeat (4) @(posedge clk);
        rd(RCNT1);
        chk("gated count", 32'h3, q);
        window(RRUN, 32'h0, 1);
        wr(RRUN, 32'h2);
        rd(RCNT1);
        chk("run keeps count", 32'h3, q);
        wr(RRUN, 32'h0);
        $display("test gate done");
        wr(RMODE, 32'h01);
        for (int c = 0; c < 5; c++) begin
            wr(RCLK, c < 4 ? c : 32'h04);
            wr(RCNT0, 32'h0);
            window(RRUN, 32'h1, 480);
            rd(RCNT0);
            e = 483 / dv[c];
            chkr("classic clock", e - 1, e + 1, q);
        end
        for (int m = 0; m < 2; m++) begin
            for (int c = 0; c < 4; c++) begin
                wr(ar(m, qct_pkg::AR_REL), 32'h0);
                wr(ar(m, qct_pkg::AR_CNT), 32'h0);
                window(ar(m, qct_pkg::AR_CTRL), 32'h1 | (c << 4), 480);
                rd(ar(m, qct_pkg::AR_CNT));
                e = 483 / ard[m][c];
                chkr("reload timer clock", e - 1, e + 1, q);
            end
        end
        $display("test clock sources done");
        wr(ar(1, qct_pkg::AR_REL), 32'hfff0);
        wr(ar(1, qct_pkg::AR_CNT), 32'hfff0);
        window(ar(1, qct_pkg::AR_CTRL), 32'h1, 40);
        rd(ar(1, qct_pkg::AR_CNT));
        chkr("reload range", 32'hfff0, 32'hffff, q);
        wr(ar(0, qct_pkg::AR_REL), 32'hf0f0);
        wr(ar(0, qct_pkg::AR_CNT), 32'hf0f0);
        window(ar(0, qct_pkg::AR_CTRL), 32'h3, 40);
        rd(ar(0, qct_pkg::AR_CNT));
        chk("split halves", 32'hf0f0, q & 32'hf0f0);
        rd(RSTS);
        chk("reload flags", 32'h2c, q);
        wr(ar(0, qct_pkg::AR_CNT), 32'h0);
        wr(ar(0, qct_pkg::AR_CTRL), 32'h0d);
        repeat (30) @(posedge clk);
        rd(ar(0, qct_pkg::AR_CAP));
        q2 = q;
        repeat (25) @(posedge clk);
        rd(ar(0, qct_pkg::AR_CAP));
        chk("capture period", 32'h0, (q - q2) % 10);
        chkr("capture advance", 10, 40, q - q2);
        $display("test auto-reload done");
        wr(RSTS, 32'hff);
        wr(RMODE, 32'h03);
        wr(RCLK, 32'h04);
        wr(RCNT0, 32'hfe00);
        window(RRUN, 32'h2, 8);
        rd(RCNT0);
        chk("split low idle", 32'h0, q & 32'hff);
        rd(RSTS);
        chk("split high flag", 32'h02, q & 32'h03);
        chk("masked irq", 32'h0, {31'h0, irq});
        wr(RMASK, 32'h2);
        repeat (2) @(posedge clk);
        chk("unmasked irq", 32'h1, {31'h0, irq});
        wr(RMASK, 32'h0);
        repeat (2) @(posedge clk);
        chk("remasked irq", 32'h0, {31'h0, irq});
        $display("test split and interrupt done");
        report_and_stop();
    end
endmodule : tb
bind quad_counter_timer_unit qct_monitor u_mon (.clk(clk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq));
`default_nettype wire
